/* hw/csp_cmd_pkg.sv */
// Package with register map, field positions, scaling and state types of the csp command path.
package csp_cmd_pkg;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [15:0] COMM_EXTENDED_SETUP_ONE_OFS = 16'h3722;
	localparam logic [15:0] COMM_EXTENDED_SETUP_THREE_OFS = 16'h3724;
	localparam logic [15:0] MAX_MOTOR_SPEED_LIMIT_OFS = 16'h6080;

	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int SAT_ENABLE_BIT = 5;
	localparam int FOLLOW_EXCL_BIT = 11;
	localparam int STATUS_INT_LIMIT_BIT = 11;
	localparam int STATUS_FOLLOWS_BIT = 12;
	localparam logic [15:0] SETUP_ONE_RESET = 16'h0000;
	localparam logic [15:0] SETUP_THREE_RESET = 16'h0000;
	localparam logic [31:0] MAX_SPEED_RESET = 32'h0000_0000;

	// ----------------------------------------------------------------
	// Timing: settle time after servo on before updates are expected
	// ----------------------------------------------------------------
	localparam int SERVO_ON_SETTLE_MS = 100;
	localparam int CLK_MHZ = 200;
	localparam int SERVO_ON_SETTLE_CYC = SERVO_ON_SETTLE_MS * 1000 * CLK_MHZ;

	// ----------------------------------------------------------------
	// Control modes and types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		MODE_CSP = 3'b001,
		MODE_CSV = 3'b010,
		MODE_CST = 3'b100
	} ctrl_mode_e;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_RUN = 3'b010,
		ST_HOLD = 3'b100
	} cmd_state_e;

	typedef struct packed {
		logic valid;
		logic signed [31:0] target;
		logic signed [31:0] offset;
		logic signed [15:0] analog_mv;
	} cyc_cmd_s;

	typedef struct packed {
		logic op_enabled;
		logic decel;
		logic torque_limit;
		logic speed_limit;
	} drive_state_s;

	typedef struct packed {
		logic wr;
		logic [15:0] addr;
		logic [31:0] wdata;
	} reg_req_s;

endpackage : csp_cmd_pkg

/* hw/csp_cmd_saturation.sv */
// Cyclic position command builder with per-cycle change saturation and status bits.
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------
// Functional notes
// - Setup-three bit 11 low: torque/cst-speed limiting clears follows bit.
// - Target equals host target plus offset plus analog term, absolute.
// - Interpolation period equals the communication cycle, one strobe each.
// - A lost target is estimated by extrapolation and trajectory stays continuous.
// - Setup-one bit 5 enables change saturation in csp.
// - Saturation acts only in cyclic position mode.
// - Maximum speed is unsigned rpm, clamped to motor maximum speed.
// - Per-cycle command change limited to step derived from maximum speed.
// - Large steps are spread over cycles so no command-change error.
// - Zero maximum speed gives zero allowed change; motor stays.
// - Zero-speed hold does not set the internal-limit status bit.
// - Follows bit is high only while operation is enabled and the drive is not decelerating, in any control mode.
// - Analog term is voltage in mV times gain in units per mV.
// ----------------------------------------------------------------
module csp_cmd_saturation #(
	parameter logic [31:0] MOTOR_MAX_RPM = 32'h0000_1770,
	parameter logic [31:0] STEP_SCALE = 32'h0000_0001,
	parameter int STEP_SHIFT = 8,
	parameter logic signed [31:0] CHANGE_ERR_LIMIT = 32'h0010_0000
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire csp_cmd_pkg::reg_req_s reg_req,
	output logic [31:0] reg_rdata,
	input wire csp_cmd_pkg::ctrl_mode_e ctrl_mode,
	input wire csp_cmd_pkg::cyc_cmd_s cyc_cmd,
	input wire logic cyc_lost,
	input wire logic signed [15:0] analog_gain,
	input wire csp_cmd_pkg::drive_state_s drive_state,
	output logic signed [31:0] pos_cmd,
	output logic pos_cmd_valid,
	output logic command_change_error,
	output logic follows_command,
	output logic internal_limit_active
);

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [15:0] setup_one_reg, setup_one_next;
	logic [15:0] setup_three_reg, setup_three_next;
	logic [31:0] max_speed_reg, max_speed_next;
	logic [31:0] rdata_reg, rdata_next;

	always_comb begin
		setup_one_next = setup_one_reg;
		setup_three_next = setup_three_reg;
		max_speed_next = max_speed_reg;
		rdata_next = 32'h0000_0000;
		if (reg_req.addr == csp_cmd_pkg::COMM_EXTENDED_SETUP_ONE_OFS) begin
			rdata_next = {16'h0000, setup_one_reg};
			if (reg_req.wr) begin
				setup_one_next = reg_req.wdata[15:0];
			end
		end else if (reg_req.addr == csp_cmd_pkg::COMM_EXTENDED_SETUP_THREE_OFS) begin
			rdata_next = {16'h0000, setup_three_reg};
			if (reg_req.wr) begin
				setup_three_next = reg_req.wdata[15:0];
			end
		end else if (reg_req.addr == csp_cmd_pkg::MAX_MOTOR_SPEED_LIMIT_OFS) begin
			rdata_next = max_speed_reg;
			if (reg_req.wr) begin
				max_speed_next = reg_req.wdata;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			setup_one_reg <= csp_cmd_pkg::SETUP_ONE_RESET;
			setup_three_reg <= csp_cmd_pkg::SETUP_THREE_RESET;
			max_speed_reg <= csp_cmd_pkg::MAX_SPEED_RESET;
			rdata_reg <= 32'h0000_0000;
		end else begin
			setup_one_reg <= setup_one_next;
			setup_three_reg <= setup_three_next;
			max_speed_reg <= max_speed_next;
			rdata_reg <= rdata_next;
		end
	end

	assign reg_rdata = rdata_reg;

	// ----------------------------------------------------------------
	// Step limit
	// ----------------------------------------------------------------
	logic [31:0] speed_eff;
	logic [63:0] step_prod;
	logic signed [31:0] step_lim;
	logic sat_on;

	assign speed_eff = (max_speed_reg > MOTOR_MAX_RPM) ? MOTOR_MAX_RPM : max_speed_reg;
	assign step_prod = (64'(speed_eff) * 64'(STEP_SCALE)) >> STEP_SHIFT;
	assign step_lim = (step_prod > 64'(32'h7FFF_FFFF)) ? 32'sh7FFF_FFFF : signed'(step_prod[31:0]);
	assign sat_on = setup_one_reg[csp_cmd_pkg::SAT_ENABLE_BIT] && (ctrl_mode == csp_cmd_pkg::MODE_CSP);

	function automatic logic signed [31:0] clamp_step(input logic signed [31:0] d,
			input logic signed [31:0] lim);
		if (d > lim) begin
			clamp_step = lim;
		end else if (d < -lim) begin
			clamp_step = -lim;
		end else begin
			clamp_step = d;
		end
	endfunction : clamp_step

	// ----------------------------------------------------------------
	// Command path
	// ----------------------------------------------------------------
	csp_cmd_pkg::cmd_state_e state_reg, state_next;
	logic signed [31:0] cmd_reg, cmd_next;
	logic signed [31:0] last_delta_reg, last_delta_next;
	logic valid_reg, valid_next;
	logic err_reg, err_next;
	logic ila_reg, ila_next;
	logic signed [31:0] analog_amt;
	logic signed [31:0] demand;
	logic signed [31:0] delta;
	logic signed [31:0] step;

	assign analog_amt = 32'(cyc_cmd.analog_mv * analog_gain);

	always_comb begin
		state_next = state_reg;
		cmd_next = cmd_reg;
		last_delta_next = last_delta_reg;
		valid_next = 1'b0;
		err_next = 1'b0;
		ila_next = sat_on ? ila_reg : 1'b0;
		demand = 32'(cyc_cmd.target + cyc_cmd.offset + analog_amt);
		delta = 32'(demand - cmd_reg);
		step = delta;
		case (state_reg)
			csp_cmd_pkg::ST_IDLE: begin
				if (cyc_cmd.valid && !cyc_lost) begin
					cmd_next = demand;
					valid_next = 1'b1;
					state_next = csp_cmd_pkg::ST_RUN;
				end
			end
			csp_cmd_pkg::ST_RUN, csp_cmd_pkg::ST_HOLD: begin
				if (cyc_cmd.valid && cyc_lost) begin
					cmd_next = 32'(cmd_reg + last_delta_reg);
					valid_next = 1'b1;
				end else if (cyc_cmd.valid) begin
					if (sat_on) begin
						step = clamp_step(delta, step_lim);
						ila_next = (step != delta) && (step_lim != 32'sh0000_0000);
					end else begin
						ila_next = 1'b0;
						err_next = (delta > CHANGE_ERR_LIMIT) || (delta < -CHANGE_ERR_LIMIT);
					end
					cmd_next = 32'(cmd_reg + step);
					last_delta_next = step;
					valid_next = 1'b1;
					state_next = (step != delta) ? csp_cmd_pkg::ST_HOLD : csp_cmd_pkg::ST_RUN;
				end
				if (!drive_state.op_enabled) begin
					state_next = csp_cmd_pkg::ST_IDLE;
					last_delta_next = 32'sh0000_0000;
					ila_next = 1'b0;
				end
			end
			default: begin
				state_next = csp_cmd_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= csp_cmd_pkg::ST_IDLE;
			cmd_reg <= 32'sh0000_0000;
			last_delta_reg <= 32'sh0000_0000;
			valid_reg <= 1'b0;
			err_reg <= 1'b0;
			ila_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cmd_reg <= cmd_next;
			last_delta_reg <= last_delta_next;
			valid_reg <= valid_next;
			err_reg <= err_next;
			ila_reg <= ila_next;
		end
	end

	assign pos_cmd = cmd_reg;
	assign pos_cmd_valid = valid_reg;
	assign command_change_error = err_reg;
	assign internal_limit_active = ila_reg;

	// ----------------------------------------------------------------
	// Follows-command status
	// ----------------------------------------------------------------
	logic follows_reg, follows_next;
	logic limit_clears;

	assign limit_clears = !setup_three_reg[csp_cmd_pkg::FOLLOW_EXCL_BIT] &&
		(drive_state.torque_limit || (drive_state.speed_limit && ctrl_mode == csp_cmd_pkg::MODE_CST));

	always_comb begin
		follows_next = drive_state.op_enabled && !drive_state.decel && !limit_clears;
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			follows_reg <= 1'b0;
		end else begin
			follows_reg <= follows_next;
		end
	end

	assign follows_command = follows_reg;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	AST_FOLLOWS_TORQUE: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(drive_state.torque_limit && !setup_three_reg[csp_cmd_pkg::FOLLOW_EXCL_BIT])
		|=> !follows_command)
		else $error("follows bit set under torque limit");
	AST_FOLLOWS_OP: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!drive_state.op_enabled |=> !follows_command)
		else $error("follows bit set outside operation enabled");
	AST_SUM_FIRST: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(state_reg == csp_cmd_pkg::ST_IDLE && cyc_cmd.valid && !cyc_lost)
		|=> pos_cmd == $past(demand))
		else $error("initial command not the summed target");
	AST_STEP_BOUND: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(state_reg != csp_cmd_pkg::ST_IDLE && sat_on && cyc_cmd.valid && !cyc_lost)
		|=> (pos_cmd - $past(pos_cmd) <= $past(step_lim)) && ($past(pos_cmd) - pos_cmd <= $past(step_lim)))
		else $error("command change exceeds step limit");
	AST_NO_ERR_SAT: assert property (@(posedge ref_clk) disable iff (!rst_n)
		sat_on |=> !command_change_error)
		else $error("change error raised with saturation on");
	AST_ZERO_SPEED: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(state_reg != csp_cmd_pkg::ST_IDLE && sat_on && max_speed_reg == 32'h0 && cyc_cmd.valid
		&& !cyc_lost && drive_state.op_enabled) |=> $stable(pos_cmd) && !internal_limit_active)
		else $error("command moved or limit flagged at zero speed");
	AST_SAT_MODE: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(ctrl_mode != csp_cmd_pkg::MODE_CSP) |=> !internal_limit_active)
		else $error("saturation active outside csp");
	AST_LOST_EXTRAP: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(state_reg != csp_cmd_pkg::ST_IDLE && cyc_cmd.valid && cyc_lost)
		|=> pos_cmd == $past(cmd_reg) + $past(last_delta_reg))
		else $error("lost cycle not extrapolated");
	// The largest step that the motor's own top speed allows; no setting may exceed it.
	localparam logic [63:0] MOTOR_MAX_STEP = (64'(MOTOR_MAX_RPM) * 64'(STEP_SCALE)) >> STEP_SHIFT;
	AST_CLAMP: assert property (@(posedge ref_clk) disable iff (!rst_n)
		64'($unsigned(step_lim)) <= MOTOR_MAX_STEP)
		else $error("step limit above motor maximum speed");
	AST_FOLLOWS_EXCL: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(setup_three_reg[csp_cmd_pkg::FOLLOW_EXCL_BIT] && drive_state.op_enabled
		&& !drive_state.decel) |=> follows_command)
		else $error("follows bit cleared by an excluded limit");
	AST_FOLLOWS_DECEL: assert property (@(posedge ref_clk) disable iff (!rst_n)
		drive_state.decel |=> !follows_command)
		else $error("follows bit set during deceleration");
	AST_SAT_OFF: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(state_reg != csp_cmd_pkg::ST_IDLE && !sat_on && cyc_cmd.valid && !cyc_lost)
		|=> pos_cmd == $past(demand))
		else $error("command limited with saturation off");
	AST_STEP_SYM: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(state_reg != csp_cmd_pkg::ST_IDLE && sat_on && cyc_cmd.valid && !cyc_lost
		&& delta < -step_lim) |=> pos_cmd == $past(cmd_reg) - $past(step_lim))
		else $error("negative step not limited to the same bound");
	AST_UPDATE: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(cyc_cmd.valid && !(state_reg == csp_cmd_pkg::ST_IDLE && cyc_lost)) |=> pos_cmd_valid)
		else $error("accepted update gave no command strobe");
	AST_NO_UPDATE: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!cyc_cmd.valid |=> !pos_cmd_valid)
		else $error("command strobe without an update");

	COV_SATURATE: cover property (@(posedge ref_clk) disable iff (!rst_n) internal_limit_active);
	COV_LOST: cover property (@(posedge ref_clk) disable iff (!rst_n)
		state_reg == csp_cmd_pkg::ST_RUN && cyc_cmd.valid && cyc_lost);
	COV_ERR: cover property (@(posedge ref_clk) disable iff (!rst_n) command_change_error);
	COV_FOLLOW: cover property (@(posedge ref_clk) disable iff (!rst_n) follows_command);

endmodule : csp_cmd_saturation
`default_nettype wire

/* testbench/csp_host_model.sv */
// Host controller model that feeds one command per interpolation cycle.
`timescale 1ns/100ps
`default_nettype none
module csp_host_model #(
	parameter int SETTLE_CYC = csp_cmd_pkg::SERVO_ON_SETTLE_CYC
) (
	input wire logic ref_clk,
	input wire logic op_enabled,
	output var csp_cmd_pkg::cyc_cmd_s cyc_cmd,
	output var logic cyc_lost
);
	int settle_cnt = 0;
	initial begin
		cyc_cmd = '0;
		cyc_lost = 1'b0;
	end
	// ----------------------------------------------------------------
	// Settle time after servo on
	// ----------------------------------------------------------------
	// wait after servo on
	// Updates are held back until the drive has been enabled for the settle span.
	always @(posedge ref_clk) begin
		if (!op_enabled) begin
			settle_cnt <= 0;
		end else if (settle_cnt < SETTLE_CYC) begin
			settle_cnt <= settle_cnt + 1;
		end
	end
	// ----------------------------------------------------------------
	// Command delivery
	// ----------------------------------------------------------------
	// one update per cycle
	// The caller supplies the trajectory point, and the strobe lasts one cycle.
	// sum tracks position
	// Callers send the current command as the sum when entering csp.
	task automatic send(input logic signed [31:0] t, input logic signed [31:0] o,
		input logic signed [15:0] mv, input logic lost);
		@(negedge ref_clk);
		while (settle_cnt < SETTLE_CYC) begin
			@(negedge ref_clk);
		end
		cyc_cmd = '{valid: 1'b1, target: t, offset: o, analog_mv: mv};
		cyc_lost = lost;
		@(negedge ref_clk);
		// The stale target is inverted so nothing relies on it after the strobe.
		cyc_cmd = '{valid: 1'b0, target: ~t, offset: o, analog_mv: mv};
		cyc_lost = 1'b0;
	endtask : send
endmodule : csp_host_model
`default_nettype wire

/* testbench/cyclic_position_command_saturation_tb.sv */
// Self-checking bench for the csp command builder.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fails++; \
	$display("ERROR %0t mismatch %h exp %h", $time, a, b); end end
module cyclic_position_command_saturation_tb;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	csp_cmd_pkg::reg_req_s reg_req = '0;
	logic [31:0] reg_rdata;
	csp_cmd_pkg::ctrl_mode_e ctrl_mode = csp_cmd_pkg::MODE_CSP;
	csp_cmd_pkg::cyc_cmd_s cyc_cmd;
	logic cyc_lost;
	logic signed [15:0] analog_gain = 16'sh0004;
	csp_cmd_pkg::drive_state_s drive_state = '0;
	logic signed [31:0] pos_cmd;
	logic pos_cmd_valid, command_change_error, follows_command, internal_limit_active;
	logic signed [31:0] p;
	int fails = 0;
	int total_checks = 0;
	always #2.5 ref_clk = ~ref_clk;
	// The settle span is cut short so that the run stays brief; the device does not check it.
	csp_host_model #(.SETTLE_CYC(16)) csp_host_model_i (.ref_clk(ref_clk),
		.op_enabled(drive_state.op_enabled), .cyc_cmd(cyc_cmd), .cyc_lost(cyc_lost));
	csp_cmd_saturation csp_cmd_saturation_i (.ref_clk(ref_clk), .rst_n(rst_n),
		.reg_req(reg_req), .reg_rdata(reg_rdata), .ctrl_mode(ctrl_mode),
		.cyc_cmd(cyc_cmd), .cyc_lost(cyc_lost), .analog_gain(analog_gain),
		.drive_state(drive_state), .pos_cmd(pos_cmd), .pos_cmd_valid(pos_cmd_valid),
		.command_change_error(command_change_error), .follows_command(follows_command),
		.internal_limit_active(internal_limit_active));
	// ----------------------------------------------------------------
	// Access tasks
	// ----------------------------------------------------------------
	task automatic reg_wr(input logic [15:0] a, input logic [31:0] d);
		@(negedge ref_clk);
		reg_req = '{wr: 1'b1, addr: a, wdata: d};
		@(negedge ref_clk);
		reg_req.wr = 1'b0;
	endtask : reg_wr
	task automatic reg_rd(input logic [15:0] a, input logic [31:0] e);
		@(negedge ref_clk);
		reg_req = '{wr: 1'b0, addr: a, wdata: 32'h0000_0000};
		@(negedge ref_clk);
		`CHK(reg_rdata, e)
	endtask : reg_rd
	task automatic snd(input logic signed [31:0] t, input logic lost, input logic ee,
		input logic ei);
		csp_host_model_i.send(t, 32'sh0000_0000, 16'sh0000, lost);
		`CHK(pos_cmd_valid, 1'b1)
		`CHK(pos_cmd, p)
		`CHK(command_change_error, ee)
		`CHK(internal_limit_active, ei)
	endtask : snd
	task automatic fol(input csp_cmd_pkg::ctrl_mode_e m, input logic [3:0] ds, input logic e);
		@(negedge ref_clk);
		ctrl_mode = m;
		drive_state = ds;
		repeat (2) @(negedge ref_clk);
		`CHK(follows_command, e)
	endtask : fol
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : give_verdict
	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		repeat (10) @(negedge ref_clk);
		rst_n = 1'b1;
		reg_rd(csp_cmd_pkg::COMM_EXTENDED_SETUP_ONE_OFS, csp_cmd_pkg::SETUP_ONE_RESET);
		reg_rd(csp_cmd_pkg::COMM_EXTENDED_SETUP_THREE_OFS, csp_cmd_pkg::SETUP_THREE_RESET);
		reg_rd(csp_cmd_pkg::MAX_MOTOR_SPEED_LIMIT_OFS, csp_cmd_pkg::MAX_SPEED_RESET);
		reg_wr(16'h1234, 32'h5555_AAAA);
		reg_rd(16'h1234, 32'h0000_0000);
		reg_wr(csp_cmd_pkg::MAX_MOTOR_SPEED_LIMIT_OFS, 32'h0000_0A00);
		reg_rd(csp_cmd_pkg::MAX_MOTOR_SPEED_LIMIT_OFS, 32'h0000_0A00);
		drive_state = 4'b1000;
		p = 32'sh0000_04BC;
		// Target 1000, offset 200, 3 mV at gain 4.
		csp_host_model_i.send(32'sh0000_03E8, 32'sh0000_00C8, 16'sh0003, 1'b0);
		`CHK(pos_cmd, p)
		p = 32'sh0020_03E8;
		snd(p, 1'b0, 1'b1, 1'b0);
		reg_wr(csp_cmd_pkg::COMM_EXTENDED_SETUP_ONE_OFS, 32'h0000_0020);
		reg_rd(csp_cmd_pkg::COMM_EXTENDED_SETUP_ONE_OFS, 32'h0000_0020);
		p = p - 10;
		snd(32'sh0000_0000, 1'b0, 1'b0, 1'b1);
		p = p + 10;
		snd(32'sh0700_0000, 1'b0, 1'b0, 1'b1);
		p = p + 10;
		snd(32'sh0000_0000, 1'b1, 1'b0, 1'b1);
		reg_wr(csp_cmd_pkg::MAX_MOTOR_SPEED_LIMIT_OFS, 32'hFFFF_FFFF);
		p = p + 23;
		snd(32'sh0700_0000, 1'b0, 1'b0, 1'b1);
		reg_wr(csp_cmd_pkg::MAX_MOTOR_SPEED_LIMIT_OFS, 32'h0000_0000);
		snd(32'sh0700_0000, 1'b0, 1'b0, 1'b0);
		reg_wr(csp_cmd_pkg::MAX_MOTOR_SPEED_LIMIT_OFS, 32'h0000_0A00);
		p = p + 10;
		snd(32'sh0700_0000, 1'b0, 1'b0, 1'b1);
		// Leaving csp must drop the flag and pass the next step unlimited.
		ctrl_mode = csp_cmd_pkg::MODE_CSV;
		csp_host_model_i.send(32'sh0000_0000, 32'sh0000_0000, 16'sh0000, 1'b0);
		`CHK(internal_limit_active, 1'b0)
		`CHK(pos_cmd, 32'sh0000_0000)
		`CHK(command_change_error, 1'b1)
		fol(csp_cmd_pkg::MODE_CSP, 4'b1000, 1'b1);
		fol(csp_cmd_pkg::MODE_CSP, 4'b1100, 1'b0);
		fol(csp_cmd_pkg::MODE_CSP, 4'b1010, 1'b0);
		fol(csp_cmd_pkg::MODE_CSP, 4'b1001, 1'b1);
		fol(csp_cmd_pkg::MODE_CST, 4'b1001, 1'b0);
		fol(csp_cmd_pkg::MODE_CSP, 4'b0000, 1'b0);
		reg_wr(csp_cmd_pkg::COMM_EXTENDED_SETUP_THREE_OFS, 32'h0000_0800);
		fol(csp_cmd_pkg::MODE_CSP, 4'b1010, 1'b1);
		fol(csp_cmd_pkg::MODE_CST, 4'b1001, 1'b1);
		give_verdict();
	end
	// The whole sequence takes under 200 cycles, so this span leaves wide margin.
	initial begin
		#20000;
		fails++;
		$display("ERROR %0t watchdog expired", $time);
		give_verdict();
	end
endmodule : cyclic_position_command_saturation_tb
`default_nettype wire
